// ---- hw/psibs_pkg.sv ----
// Package: constants, modes and types of the pseudo-static RAM front end
package psibs_pkg;
	localparam int CLK_MHZ             = 200;
	localparam int INIT_WAIT_US        = 300;
	localparam int INIT_WAIT_CYC       = INIT_WAIT_US * CLK_MHZ;
	localparam int PAGE_WORDS          = 16;
	localparam int ADDR_W              = 23;
	localparam int PAGE_BITS           = 4;
	// APB byte addresses
	localparam logic [7:0] OFS_MODE    = 8'h00;
	localparam logic [7:0] OFS_STATUS  = 8'h04;
	localparam logic [7:0] OFS_ADDR    = 8'h08;
	// Mode register fields
	localparam int MODE_DEN_LSB        = 0;
	localparam int MODE_BL_LSB         = 2;
	localparam int MODE_BURST_BIT      = 4;
	localparam int MODE_EDGE_BIT       = 5;
	localparam int MODE_SW_BIT         = 6;
	localparam int MODE_RL_LSB         = 8;
	localparam logic [31:0] MODE_RESET = 32'h0000_0500;
	localparam logic [3:0] RL_MIN      = 4'h5;
	localparam logic [3:0] RL_MAX      = 4'hA;
	// Retained-region last word addresses
	localparam logic [22:0] END_32M    = 23'h1F_FFFF;
	localparam logic [22:0] END_16M    = 23'h0F_FFFF;
	localparam logic [22:0] END_8M     = 23'h07_FFFF;
	typedef enum logic [1:0] {
		PSIBS_DEN_32M = 2'h0,
		PSIBS_DEN_16M = 2'h1,
		PSIBS_DEN_8M  = 2'h2,
		PSIBS_DEN_0M  = 2'h3
	} psibs_den_t;
	typedef enum logic [1:0] {
		PSIBS_BL_8    = 2'h0,
		PSIBS_BL_16   = 2'h1,
		PSIBS_BL_CONT = 2'h2
	} psibs_bl_t;
	typedef enum logic [2:0] {
		PSIBS_UNINIT  = 3'b000,
		PSIBS_INITW   = 3'b001,
		PSIBS_IDLE    = 3'b011,
		PSIBS_ACTIVE  = 3'b010,
		PSIBS_DEEP    = 3'b110
	} psibs_state_t;
	typedef enum logic [1:0] {
		PSIBS_OP_NONE  = 2'h0,
		PSIBS_OP_PAGE  = 2'h1,
		PSIBS_OP_BRD   = 2'h2,
		PSIBS_OP_BWR   = 2'h3
	} psibs_op_t;
endpackage

// ---- hw/psibs_sync2.sv ----
// Two-flop synchroniser for pin levels
`timescale 1ns/10ps
`default_nettype none
module psibs_sync2 #(
	parameter int W = 1
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic [W-1:0] d,
	output var  logic [W-1:0] q
);
	logic [W-1:0] meta_reg;

	// First stage feeds only the second
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_reg <= '0;
			q        <= '0;
		end else begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end
endmodule
`default_nettype wire

// ---- hw/psibs_top.sv ----
// Device-side control of the pseudo-static RAM: init, standby, page, burst
`timescale 1ns/10ps
`default_nettype none
module psibs_top #(
	parameter int INIT_CYC = psibs_pkg::INIT_WAIT_CYC
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	input  wire logic        chip_select_n,
	input  wire logic        sleep_control,
	input  wire logic        burst_clk,
	input  wire logic        write_n,
	input  wire logic [22:0] mem_addr,
	output var  logic [22:0] array_addr,
	output var  logic        array_rd,
	output var  logic        array_wr,
	output var  logic        data_valid,
	output var  logic        init_done,
	output var  logic        deep_standby,
	output var  logic        retain_ok
);
	localparam logic [23:0] INIT_N = 24'(INIT_CYC);

	typedef struct packed {
		psibs_pkg::psibs_state_t st;
		psibs_pkg::psibs_op_t    op;
		logic [23:0] timer;
		logic [31:0] mode;
		logic        mode_set;
		logic [22:0] addr;
		logic [22:0] base;
		logic [3:0]  lat;
		logic [4:0]  cnt;
		logic        clk_d;
		logic        cs_d;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
		logic        rd;
		logic        wr;
		logic        dv;
		logic        init_done;
		logic        deep;
		logic        retain;
	} psibs_s_t;

	psibs_s_t s_reg;
	psibs_s_t s_next;
	logic [26:0] pin_sync;

	// Pins cross into pclk through two flops
	psibs_sync2 #(.W(27)) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.d       ({chip_select_n, sleep_control, burst_clk, write_n,
		           mem_addr}),
		.q       (pin_sync)
	);

	logic        cs_n;
	logic        slp;
	logic        bclk;
	logic        we_n;
	logic [22:0] a;
	assign cs_n = pin_sync[26];
	assign slp  = pin_sync[25];
	assign bclk = pin_sync[24];
	assign we_n = pin_sync[23];
	assign a    = pin_sync[22:0];

	// Last retained word for a density code
	function automatic logic [22:0] den_end(input logic [1:0] d);
		case (d)
			2'h0:    den_end = psibs_pkg::END_32M;
			2'h1:    den_end = psibs_pkg::END_16M;
			2'h2:    den_end = psibs_pkg::END_8M;
			default: den_end = 23'h00_0000;
		endcase
	endfunction

	// Burst length in words, zero meaning continuous
	function automatic logic [4:0] bl_words(input logic [1:0] b);
		case (b)
			2'h0:    bl_words = 5'h08;
			2'h1:    bl_words = 5'h10;
			default: bl_words = 5'h00;
		endcase
	endfunction

	logic [1:0] den_f;
	logic [1:0] bl_f;
	logic [3:0] rl_f;
	logic       burst_en;
	logic       edge_fall;
	logic       single_wr;
	logic       clk_edge;
	logic       apb_acc;
	logic       first_word;
	logic [22:0] keep_end;
	// Retained region end for the programmed density
	assign keep_end   = den_end(den_f);
	// No word moved yet since the address was latched
	assign first_word = (s_reg.cnt == 5'h00) && (s_reg.addr == s_reg.base);
	assign den_f     = s_reg.mode[psibs_pkg::MODE_DEN_LSB +: 2];
	assign bl_f      = s_reg.mode[psibs_pkg::MODE_BL_LSB +: 2];
	assign rl_f      = s_reg.mode[psibs_pkg::MODE_RL_LSB +: 4];
	assign burst_en  = s_reg.mode[psibs_pkg::MODE_BURST_BIT];
	assign edge_fall = s_reg.mode[psibs_pkg::MODE_EDGE_BIT];
	assign single_wr = s_reg.mode[psibs_pkg::MODE_SW_BIT];
	// Programmed edge of the burst clock, seen in pclk time
	assign clk_edge  = edge_fall ? (s_reg.clk_d & ~bclk)
	                             : (~s_reg.clk_d & bclk);
	assign apb_acc   = psel & penable & ~s_reg.pready;

	// Next-state logic
	always_comb begin
		s_next        = s_reg;
		s_next.clk_d  = bclk;
		// Marks the first selected cycle; a finished burst must not restart
		s_next.cs_d   = (s_reg.st != psibs_pkg::PSIBS_ACTIVE);
		s_next.rd     = 1'b0;
		s_next.wr     = 1'b0;
		s_next.dv     = 1'b0;
		s_next.pready = 1'b0;
		// APB slave, one wait state
		if (apb_acc) begin
			s_next.pready  = 1'b1;
			s_next.pslverr = 1'b0;
			s_next.prdata  = 32'h0000_0000;
			case (paddr)
				psibs_pkg::OFS_MODE: begin
					if (!pwrite)
						s_next.prdata = s_reg.mode;
				end
				psibs_pkg::OFS_STATUS: begin
					s_next.prdata = {24'h00_0000, 1'b0, s_reg.op,
					                 s_reg.st, s_reg.mode_set,
					                 s_reg.init_done};
				end
				psibs_pkg::OFS_ADDR: begin
					s_next.prdata = {9'h000, s_reg.addr};
				end
				default: begin
					s_next.pslverr = 1'b1;
				end
			endcase
		end
		// Write lands on the edge that completes the transfer
		if (psel && penable && s_reg.pready && pwrite &&
		    paddr == psibs_pkg::OFS_MODE) begin
			s_next.mode = pwdata;
			// Keep latency in its legal range
			if (pwdata[psibs_pkg::MODE_RL_LSB +: 4] < psibs_pkg::RL_MIN ||
			    pwdata[psibs_pkg::MODE_RL_LSB +: 4] > psibs_pkg::RL_MAX)
				s_next.mode[psibs_pkg::MODE_RL_LSB +: 4] =
				    psibs_pkg::RL_MIN;
			s_next.mode_set = 1'b1;
		end
		// Power state machine
		case (s_reg.st)
			psibs_pkg::PSIBS_UNINIT: begin
				s_next.init_done = 1'b0;
				s_next.timer     = 24'h00_0000;
				if (slp && cs_n)
					s_next.st = psibs_pkg::PSIBS_INITW;
			end
			psibs_pkg::PSIBS_INITW: begin
				// Host must keep both pins high the whole wait
				if (!slp || !cs_n) begin
					s_next.st = psibs_pkg::PSIBS_UNINIT;
				end else if (s_reg.timer >= INIT_N - 24'h00_0001) begin
					s_next.st        = psibs_pkg::PSIBS_IDLE;
					s_next.init_done = 1'b1;
				end else begin
					s_next.timer = s_reg.timer + 24'h00_0001;
				end
			end
			psibs_pkg::PSIBS_IDLE,
			psibs_pkg::PSIBS_ACTIVE: begin
				if (!slp) begin
					s_next.st     = psibs_pkg::PSIBS_DEEP;
					s_next.op     = psibs_pkg::PSIBS_OP_NONE;
					s_next.deep   = 1'b1;
					s_next.retain = (keep_end != 23'h00_0000);
				end else if (cs_n) begin
					// Deselect ends page or burst
					s_next.st = psibs_pkg::PSIBS_IDLE;
					s_next.op = psibs_pkg::PSIBS_OP_NONE;
				end else begin
					s_next.st = psibs_pkg::PSIBS_ACTIVE;
				end
			end
			psibs_pkg::PSIBS_DEEP: begin
				if (slp) begin
					s_next.deep = 1'b0;
					if (den_f == 2'h3) begin
						// Nothing kept: full power-up again
						s_next.st        = psibs_pkg::PSIBS_UNINIT;
						s_next.init_done = 1'b0;
					end else begin
						s_next.st = psibs_pkg::PSIBS_IDLE;
					end
				end
			end
			default: s_next.st = psibs_pkg::PSIBS_UNINIT;
		endcase
		// Access engine while selected
		if (s_reg.st == psibs_pkg::PSIBS_ACTIVE && slp && !cs_n) begin
			if (s_reg.cs_d) begin
				// New access: burst only once programmed
				if (burst_en && s_reg.mode_set) begin
					s_next.op   = we_n ? psibs_pkg::PSIBS_OP_BRD
					                   : psibs_pkg::PSIBS_OP_BWR;
					s_next.base = a;
					s_next.addr = a;
					s_next.cnt  = 5'h00;
					s_next.lat  = we_n ? rl_f
					                   : rl_f - 4'h1;
				end else begin
					s_next.op   = psibs_pkg::PSIBS_OP_PAGE;
					s_next.addr = a;
					s_next.rd   = 1'b1;
					s_next.dv   = 1'b1;
				end
			end else if (s_reg.op == psibs_pkg::PSIBS_OP_PAGE) begin
				// Low four bits move within the page
				if (a[22:psibs_pkg::PAGE_BITS] !=
				    s_reg.addr[22:psibs_pkg::PAGE_BITS]) begin
					s_next.addr = a;
					s_next.rd   = 1'b1;
					s_next.dv   = 1'b1;
				end else if (a != s_reg.addr) begin
					s_next.addr = a;
					s_next.rd   = 1'b1;
					s_next.dv   = 1'b1;
				end
			end else if (s_reg.op != psibs_pkg::PSIBS_OP_NONE &&
			             clk_edge) begin
				if (s_reg.lat > 4'h1) begin
					s_next.lat = s_reg.lat - 4'h1;
				end else begin
					s_next.lat = 4'h1;
					s_next.rd  = (s_reg.op == psibs_pkg::PSIBS_OP_BRD);
					s_next.wr  = (s_reg.op == psibs_pkg::PSIBS_OP_BWR);
					s_next.dv  = 1'b1;
					s_next.cnt  = s_reg.cnt + 5'h01;
					// First word at the latched address; wrap in 8- or 16-word boundary, continuous runs on
					if (first_word)
						s_next.addr = s_reg.addr;
					else if (bl_f == 2'h0)
						s_next.addr = {s_reg.addr[22:3],
						               s_reg.addr[2:0] + 3'h1};
					else if (bl_f == 2'h1)
						s_next.addr = {s_reg.addr[22:4],
						               s_reg.addr[3:0] + 4'h1};
					else
						s_next.addr = s_reg.addr + 23'h00_0001;
					// Burst ends at its fixed length, or after one word per write in single-write mode
					if ((bl_words(bl_f) != 5'h00 &&
					     s_reg.cnt + 5'h01 == bl_words(bl_f)) ||
					    (single_wr &&
					     s_reg.op == psibs_pkg::PSIBS_OP_BWR))
						s_next.op = psibs_pkg::PSIBS_OP_NONE;
				end
			end
		end
		s_next.retain = s_next.deep ? s_next.retain : 1'b1;
	end

	// Single state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg      <= '0;
			s_reg.mode <= psibs_pkg::MODE_RESET;
			s_reg.st   <= psibs_pkg::PSIBS_UNINIT;
			s_reg.cs_d <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	// Outputs straight from the state register
	assign prdata       = s_reg.prdata;
	assign pready       = s_reg.pready;
	assign pslverr      = s_reg.pslverr;
	assign array_addr   = s_reg.addr;
	assign array_rd     = s_reg.rd;
	assign array_wr     = s_reg.wr;
	assign data_valid   = s_reg.dv;
	assign init_done    = s_reg.init_done;
	assign deep_standby = s_reg.deep;
	assign retain_ok    = s_reg.retain;

	property p_init_time;
		@(posedge pclk) disable iff (!presetn)
		$rose(s_reg.init_done) |-> $past(s_reg.st) == psibs_pkg::PSIBS_INITW;
	endproperty
	a_init_time: assert property (p_init_time)
		else $error("init done without wait");

	property p_deep;
		@(posedge pclk) disable iff (!presetn)
		(!slp && s_reg.init_done) |=> s_reg.deep;
	endproperty
	a_deep: assert property (p_deep)
		else $error("deep standby not entered");

	property p_zero_reinit;
		@(posedge pclk) disable iff (!presetn)
		(s_reg.st == psibs_pkg::PSIBS_DEEP && slp && den_f == 2'h3)
		|=> !s_reg.init_done;
	endproperty
	a_zero_reinit: assert property (p_zero_reinit)
		else $error("0M exit skipped init");

	property p_page_upper;
		@(posedge pclk) disable iff (!presetn)
		(s_reg.st == psibs_pkg::PSIBS_ACTIVE &&
		 s_reg.op == psibs_pkg::PSIBS_OP_PAGE && !cs_n && slp &&
		 a[22:4] != s_reg.addr[22:4]) |=> s_reg.rd;
	endproperty
	a_page_upper: assert property (p_page_upper)
		else $error("upper address change no new read");

	property p_no_burst;
		@(posedge pclk) disable iff (!presetn)
		!s_reg.mode_set |-> s_reg.op != psibs_pkg::PSIBS_OP_BRD;
	endproperty
	a_no_burst: assert property (p_no_burst)
		else $error("burst before mode set");

	property p_step;
		@(posedge pclk) disable iff (!presetn)
		(s_reg.dv && s_reg.op == psibs_pkg::PSIBS_OP_BRD &&
		 s_reg.cnt != 5'h01 &&
		 bl_f == 2'h2 && $past(s_reg.op) == psibs_pkg::PSIBS_OP_BRD)
		|-> s_reg.addr == $past(s_reg.addr) + 23'h00_0001;
	endproperty
	a_step: assert property (p_step)
		else $error("burst address not advanced by one");

	property p_lat;
		@(posedge pclk) disable iff (!presetn)
		s_reg.op != psibs_pkg::PSIBS_OP_NONE |->
		s_reg.lat <= psibs_pkg::RL_MAX;
	endproperty
	a_lat: assert property (p_lat)
		else $error("latency out of range");

	property p_retain;
		@(posedge pclk) disable iff (!presetn)
		$rose(s_reg.deep) |-> s_reg.retain == (den_f != 2'h3);
	endproperty
	a_retain: assert property (p_retain)
		else $error("retention flag wrong");

	c_init: cover property (@(posedge pclk) $rose(s_reg.init_done));
	c_deep: cover property (@(posedge pclk) $rose(s_reg.deep));
	c_page: cover property (@(posedge pclk)
		s_reg.op == psibs_pkg::PSIBS_OP_PAGE && s_reg.rd);
	c_burst: cover property (@(posedge pclk)
		s_reg.op == psibs_pkg::PSIBS_OP_BRD && s_reg.rd);
endmodule
`default_nettype wire

// ---- verification/psibs_host_model.sv ----
// Host controller model driving the RAM pins: power-up, selects and bursts
`timescale 1ns/10ps
`default_nettype none
module psibs_host_model #(
	parameter int LOW_CYC = 10
) (
	input  wire logic        pclk,
	output var  logic        chip_select_n,
	output var  logic        sleep_control,
	output var  logic        burst_clk,
	output var  logic        write_n,
	output var  logic [22:0] mem_addr
);
	// Supply comes up with sleep low and the device deselected
	initial begin
		chip_select_n = 1'b1;
		sleep_control = 1'b0; // Slow supply assumed, so method one
		burst_clk     = 1'b0;
		write_n       = 1'b1;
		mem_addr      = 23'h00_0000;
	end

	// Method one: select high before sleep rises, low phase held first
	task automatic power_up();
		chip_select_n <= 1'b1;
		sleep_control <= 1'b0;
		repeat (LOW_CYC) @(posedge pclk); // Scaled low hold
		sleep_control <= 1'b1; // Stays high unless deep standby
	endtask

	// Sleep pin change, then time for the synchroniser
	task automatic sleep(input logic v);
		sleep_control <= v;
		repeat (8) @(posedge pclk);
	endtask

	// Address and select; upper bits only change between pages
	task automatic select(input logic cs, input logic [22:0] a);
		mem_addr      <= a;
		chip_select_n <= cs;
		repeat (6) @(posedge pclk);
	endtask

	// Burst frame: link clock runs only while selected
	task automatic burst(input logic [22:0] a, input logic wr, input int edges);
		mem_addr      <= a;
		write_n       <= ~wr;
		chip_select_n <= 1'b0;
		repeat (4) @(posedge pclk);
		repeat (edges) begin
			#32 burst_clk = 1'b1;
			#32 burst_clk = 1'b0;
		end
		repeat (4) @(posedge pclk);
		chip_select_n <= 1'b1; // Also the end of continuous bursts
		write_n       <= 1'b1;
		repeat (4) @(posedge pclk);
	endtask
endmodule
`default_nettype wire

// ---- verification/psibs_top_tb_top.sv ----
// Self-checking bench for the RAM front end over APB and its pins
`timescale 1ns/10ps
`default_nettype none
module psibs_top_tb_top;
	localparam int INIT_CYC = 20;
	// Burst table: mode word, write, link edges, word count window
	localparam logic [31:0] BMODE [6] = '{32'h0000_0500, 32'h0000_0510,
		32'h0000_0534, 32'h0000_0550, 32'h0000_0510, 32'h0000_0518};
	localparam logic BWR [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
	localparam int BEDGE [6] = '{17, 17, 25, 17, 17, 29};
	localparam int BMIN [6]  = '{0, 8, 16, 1, 8, 17};
	localparam int BMAX [6]  = '{1, 8, 16, 1, 8, 40};
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        chip_select_n;
	logic        sleep_control;
	logic        burst_clk;
	logic        write_n;
	logic [22:0] mem_addr;
	logic [22:0] array_addr;
	logic        array_rd;
	logic        array_wr;
	logic        data_valid;
	logic        init_done;
	logic        deep_standby;
	logic        retain_ok;
	int          err_total = 0;
	int          cmp_count = 0;
	int          cyc       = 0;
	int          rd_cnt    = 0;
	int          dv_cnt    = 0;
	logic [22:0] seen[$];

	psibs_top #(.INIT_CYC(INIT_CYC)) DUT (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.chip_select_n(chip_select_n), .sleep_control(sleep_control),
		.burst_clk(burst_clk), .write_n(write_n), .mem_addr(mem_addr),
		.array_addr(array_addr), .array_rd(array_rd), .array_wr(array_wr),
		.data_valid(data_valid), .init_done(init_done),
		.deep_standby(deep_standby), .retain_ok(retain_ok));

	psibs_host_model host (.pclk(pclk), .chip_select_n(chip_select_n),
		.sleep_control(sleep_control), .burst_clk(burst_clk),
		.write_n(write_n), .mem_addr(mem_addr));

	// Clock at 200 MHz
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	// Word counters; cleared only while the pins are quiet
	always @(posedge pclk) begin
		cyc++;
		if (array_rd === 1'b1) rd_cnt++;
		if (data_valid === 1'b1) begin
			dv_cnt++;
			seen.push_back(array_addr);
		end
		if (cyc == 20000) begin
			err_total++;
			give_verdict();
		end
	end

	task automatic chk(input string what, input logic [31:0] got,
			input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic give_verdict();
		$display("compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// APB transfer; request held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a,
			input logic [31:0] d, output logic [31:0] q, output logic e);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	// Main sequence
	initial begin
		logic [31:0] q;
		logic        e;
		presetn = 1'b0;
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 8'h00;
		pwdata  = 32'h0000_0000;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, psibs_pkg::OFS_MODE, 32'h0000_0000, q, e);
		chk("mode reset", q, psibs_pkg::MODE_RESET);
		apb(1'b0, 8'h40, 32'h0000_0000, q, e);
		chk("unmapped error", e, 32'h0000_0001);
		chk("init at reset", init_done, 32'h0000_0000);
		$display("test reset finished");
		// Power-up: no access before the full hold
		host.power_up();
		repeat (10) @(posedge pclk);
		chk("init early", init_done, 32'h0000_0000);
		repeat (INIT_CYC) @(posedge pclk);
		chk("init done", init_done, 32'h0000_0001);
		$display("test init finished");
		// Page: odd first word, random order, then an A4 change
		rd_cnt = 0;
		host.select(1'b0, 23'h12_345B);
		chk("page first", array_addr, 32'h0012_345B);
		host.select(1'b0, 23'h12_3452);
		host.select(1'b0, 23'h12_345F);
		chk("page word", array_addr, 32'h0012_345F);
		host.select(1'b0, 23'h12_3457);
		host.select(1'b0, 23'h12_3467);
		chk("page restart", array_addr, 32'h0012_3467);
		host.select(1'b1, 23'h12_3467);
		chk("page reads", rd_cnt, 32'h0000_0005);
		$display("test page finished");
		// Latency field: legal values kept, others give 5
		for (int r = 4; r < 12; r++) begin
			apb(1'b1, psibs_pkg::OFS_MODE, {20'h0_0000, 4'(r), 8'h00}, q, e);
			apb(1'b0, psibs_pkg::OFS_MODE, 32'h0000_0000, q, e);
			chk("mode latency", q, {20'h0_0000,
				(r >= 5 && r <= 10) ? 4'(r) : 4'h5, 8'h00});
		end
		$display("test latency finished");
		// Bursts: async mode, lengths, edges, single and burst writes
		for (int k = 0; k < 6; k++) begin
			apb(1'b1, psibs_pkg::OFS_MODE, BMODE[k], q, e);
			dv_cnt = 0;
			seen.delete();
			host.burst(23'h10_0005, BWR[k], BEDGE[k]);
			chk("burst words", 32'(dv_cnt >= BMIN[k] && dv_cnt <= BMAX[k]),
				32'h0000_0001);
			if (k == 1) begin
				foreach (seen[i]) begin
					chk("burst addr", seen[i], {9'h000, 20'h2_0000,
						3'(5 + i)});
				end
			end
		end
		$display("test burst finished");
		// Deep standby for each density code, 0M included
		for (int d = 0; d < 4; d++) begin
			apb(1'b1, psibs_pkg::OFS_MODE, 32'h0000_0500 | d, q, e);
			host.sleep(1'b0);
			chk("deep entry", deep_standby, 32'h0000_0001);
			chk("retained", retain_ok, 32'(d != 3));
			host.sleep(1'b1);
			chk("deep exit", init_done, 32'(d != 3));
			apb(1'b0, psibs_pkg::OFS_MODE, 32'h0000_0000, q, e);
			chk("density kept", q[1:0], 32'(d));
		end
		host.power_up();
		repeat (INIT_CYC + 10) @(posedge pclk);
		chk("reinit done", init_done, 32'h0000_0001);
		$display("test standby finished");
		give_verdict();
	end
endmodule
`default_nettype wire
